//--- include/lfcd_pkg.sv
// constants and carriers for the loop filter coefficient decoder
// assumes apb with 32-bit data and word-aligned byte addresses
package lfcd_pkg;

  // register byte offsets
  localparam logic [7:0] ALPHA_OFF = 8'h00;
  localparam logic [7:0] BETA_OFF = 8'h04;
  localparam logic [7:0] GAMMA_OFF = 8'h08;
  localparam logic [7:0] DELTA_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;

  // field widths
  localparam int ALPHA_MANT_W = 16;
  localparam int ALPHA_SHIFT_W = 6;
  localparam int ALPHA_FRONT_W = 3;
  localparam int ALPHA_BACK_W = 4;
  localparam int BG_MANT_W = 17;
  localparam int DELTA_MANT_W = 15;
  localparam int EXP_SHIFT_W = 5;

  // field positions (low bit of each field within its word)
  localparam int ALPHA_MANT_POS = 0;
  localparam int ALPHA_SHIFT_POS = 16;
  localparam int ALPHA_FRONT_POS = 22;
  localparam int ALPHA_BACK_POS = 25;
  localparam int BG_MANT_POS = 0;
  localparam int BG_SHIFT_POS = 17;
  localparam int DELTA_MANT_POS = 0;
  localparam int DELTA_SHIFT_POS = 15;

  // base exponents and shift limits
  localparam int ALPHA_BASE_EXP = 16;
  localparam int BG_BASE_EXP = 17;
  localparam int DELTA_BASE_EXP = 15;
  localparam int ALPHA_SHIFT_MAX = 63;
  localparam int EXP_SHIFT_MAX = 31;
  localparam int ALPHA_GAIN_MAX = 22;

  // fractional bits so that the smallest scale is exact
  localparam int ALPHA_FRAC = ALPHA_BASE_EXP + ALPHA_SHIFT_MAX;
  localparam int BG_FRAC = BG_BASE_EXP + EXP_SHIFT_MAX;
  localparam int DELTA_FRAC = DELTA_BASE_EXP + EXP_SHIFT_MAX;
  localparam int ALPHA_OUT_W = ALPHA_FRAC + ALPHA_GAIN_MAX;
  localparam int BG_OUT_W = BG_FRAC + 1;
  localparam int DELTA_OUT_W = DELTA_FRAC;

  typedef struct packed {
    logic [ALPHA_BACK_W-1:0] back;
    logic [ALPHA_FRONT_W-1:0] front;
    logic [ALPHA_SHIFT_W-1:0] shift;
    logic [ALPHA_MANT_W-1:0] mant;
  } lfcd_alpha_s;

  typedef struct packed {
    logic [EXP_SHIFT_W-1:0] shift;
    logic [BG_MANT_W-1:0] mant;
  } lfcd_bg_s;

  typedef struct packed {
    logic [EXP_SHIFT_W-1:0] shift;
    logic [DELTA_MANT_W-1:0] mant;
  } lfcd_delta_s;

  // reset values
  localparam lfcd_alpha_s ALPHA_RST = '0;
  localparam lfcd_bg_s BG_RST = '0;
  localparam lfcd_delta_s DELTA_RST = '0;

endpackage : lfcd_pkg

//--- hdl/lfcd_top.sv
// loop filter coefficient decoder with apb register access
// assumes one clock pclk and an apb master obeying the usual protocol
//
// Notes on behaviour
// - alpha = mantissa * 2^(-16 - shift + front gain + back gain)
// - shift moves point left; front gain before, back gain after path
// - beta, gamma stored positive; decoder outputs them negated
// - beta, gamma magnitude = mantissa * 2^-(17+shift), mantissa 1..131071
// - delta = mantissa * 2^-(15+shift), mantissa 1..32767, shift 0..31
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module lfcd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [lfcd_pkg::ALPHA_OUT_W-1:0] alpha_coef,
  output logic signed [lfcd_pkg::BG_OUT_W-1:0] beta_coef,
  output logic signed [lfcd_pkg::BG_OUT_W-1:0] gamma_coef,
  output logic [lfcd_pkg::DELTA_OUT_W-1:0] delta_coef,
  output logic [3:0] mant_zero
);

  lfcd_pkg::lfcd_alpha_s alpha_r, alpha_nxt;
  lfcd_pkg::lfcd_bg_s beta_r, beta_nxt, gamma_r, gamma_nxt;
  lfcd_pkg::lfcd_delta_s delta_r, delta_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [lfcd_pkg::ALPHA_OUT_W-1:0] alpha_out_r, alpha_out_nxt;
  logic signed [lfcd_pkg::BG_OUT_W-1:0] beta_out_r, beta_out_nxt;
  logic signed [lfcd_pkg::BG_OUT_W-1:0] gamma_out_r, gamma_out_nxt;
  logic [lfcd_pkg::DELTA_OUT_W-1:0] delta_out_r, delta_out_nxt;
  logic [3:0] zero_r, zero_nxt;
  logic setup, done, hit;
  logic [7:0] alpha_amt;
  logic [4:0] beta_amt, gamma_amt, delta_amt;
  logic [lfcd_pkg::BG_FRAC-1:0] beta_mag, gamma_mag;
  logic [lfcd_pkg::ALPHA_OUT_W-1:0] alpha_wide;
  logic [lfcd_pkg::DELTA_OUT_W-1:0] delta_wide;

  assign setup = psel & ~penable;
  assign done = psel & penable & pready_r;
  assign hit = (paddr == lfcd_pkg::ALPHA_OFF) |
               (paddr == lfcd_pkg::BETA_OFF) |
               (paddr == lfcd_pkg::GAMMA_OFF) |
               (paddr == lfcd_pkg::DELTA_OFF) |
               (paddr == lfcd_pkg::STATUS_OFF);

  // apb slave: answer in the first access cycle
  always_comb begin
    pready_nxt = setup;
    pslverr_nxt = setup & ~hit;
    prdata_nxt = prdata_r;
    if (setup) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        lfcd_pkg::ALPHA_OFF: prdata_nxt = 32'(alpha_r);
        lfcd_pkg::BETA_OFF: prdata_nxt = 32'(beta_r);
        lfcd_pkg::GAMMA_OFF: prdata_nxt = 32'(gamma_r);
        lfcd_pkg::DELTA_OFF: prdata_nxt = 32'(delta_r);
        lfcd_pkg::STATUS_OFF: prdata_nxt = {28'h0000000, zero_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // coefficient field storage
  always_comb begin
    alpha_nxt = alpha_r;
    beta_nxt = beta_r;
    gamma_nxt = gamma_r;
    delta_nxt = delta_r;
    if (done && pwrite) begin
      unique case (paddr)
        lfcd_pkg::ALPHA_OFF: begin
          alpha_nxt.mant = pwdata[lfcd_pkg::ALPHA_MANT_POS +:
                                  lfcd_pkg::ALPHA_MANT_W];
          alpha_nxt.shift = pwdata[lfcd_pkg::ALPHA_SHIFT_POS +:
                                   lfcd_pkg::ALPHA_SHIFT_W];
          alpha_nxt.front = pwdata[lfcd_pkg::ALPHA_FRONT_POS +:
                                   lfcd_pkg::ALPHA_FRONT_W];
          alpha_nxt.back = pwdata[lfcd_pkg::ALPHA_BACK_POS +:
                                  lfcd_pkg::ALPHA_BACK_W];
        end
        lfcd_pkg::BETA_OFF: begin
          beta_nxt.mant = pwdata[lfcd_pkg::BG_MANT_POS +:
                                 lfcd_pkg::BG_MANT_W];
          beta_nxt.shift = pwdata[lfcd_pkg::BG_SHIFT_POS +:
                                  lfcd_pkg::EXP_SHIFT_W];
        end
        lfcd_pkg::GAMMA_OFF: begin
          gamma_nxt.mant = pwdata[lfcd_pkg::BG_MANT_POS +:
                                  lfcd_pkg::BG_MANT_W];
          gamma_nxt.shift = pwdata[lfcd_pkg::BG_SHIFT_POS +:
                                   lfcd_pkg::EXP_SHIFT_W];
        end
        lfcd_pkg::DELTA_OFF: begin
          delta_nxt.mant = pwdata[lfcd_pkg::DELTA_MANT_POS +:
                                  lfcd_pkg::DELTA_MANT_W];
          delta_nxt.shift = pwdata[lfcd_pkg::DELTA_SHIFT_POS +:
                                   lfcd_pkg::EXP_SHIFT_W];
        end
        default: ;
      endcase
    end
  end

  // shift amounts: exponent seen as left shift from the finest step
  assign alpha_amt = 8'(lfcd_pkg::ALPHA_SHIFT_MAX) - {2'b00, alpha_r.shift} +
                     {5'b00000, alpha_r.front} +
                     {4'h0, alpha_r.back};
  assign beta_amt = 5'(lfcd_pkg::EXP_SHIFT_MAX) - beta_r.shift;
  assign gamma_amt = 5'(lfcd_pkg::EXP_SHIFT_MAX) - gamma_r.shift;
  assign delta_amt = 5'(lfcd_pkg::EXP_SHIFT_MAX) - delta_r.shift;

  // barrel shifters: mantissa moved up from the finest step
  lfcd_shl #(
    .MANT_W(lfcd_pkg::ALPHA_MANT_W),
    .AMT_W(8),
    .OUT_W(lfcd_pkg::ALPHA_OUT_W)
  ) i_lfcd_shl_alpha (
    .mant(alpha_r.mant),
    .amt(alpha_amt),
    .shifted(alpha_wide)
  );

  lfcd_shl #(
    .MANT_W(lfcd_pkg::BG_MANT_W),
    .AMT_W(lfcd_pkg::EXP_SHIFT_W),
    .OUT_W(lfcd_pkg::BG_FRAC)
  ) i_lfcd_shl_beta (
    .mant(beta_r.mant),
    .amt(beta_amt),
    .shifted(beta_mag)
  );

  lfcd_shl #(
    .MANT_W(lfcd_pkg::BG_MANT_W),
    .AMT_W(lfcd_pkg::EXP_SHIFT_W),
    .OUT_W(lfcd_pkg::BG_FRAC)
  ) i_lfcd_shl_gamma (
    .mant(gamma_r.mant),
    .amt(gamma_amt),
    .shifted(gamma_mag)
  );

  lfcd_shl #(
    .MANT_W(lfcd_pkg::DELTA_MANT_W),
    .AMT_W(lfcd_pkg::EXP_SHIFT_W),
    .OUT_W(lfcd_pkg::DELTA_OUT_W)
  ) i_lfcd_shl_delta (
    .mant(delta_r.mant),
    .amt(delta_amt),
    .shifted(delta_wide)
  );

  // decode: values are fixed point with the named fraction widths
  always_comb begin
    alpha_out_nxt = alpha_wide;
    beta_out_nxt = -$signed({1'b0, beta_mag});
    gamma_out_nxt = -$signed({1'b0, gamma_mag});
    delta_out_nxt = delta_wide;
    // zero mantissa lies outside the allowed range
    zero_nxt = {delta_r.mant == '0, gamma_r.mant == '0,
                beta_r.mant == '0, alpha_r.mant == '0};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alpha_r <= lfcd_pkg::ALPHA_RST;
      beta_r <= lfcd_pkg::BG_RST;
      gamma_r <= lfcd_pkg::BG_RST;
      delta_r <= lfcd_pkg::DELTA_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      alpha_out_r <= '0;
      beta_out_r <= '0;
      gamma_out_r <= '0;
      delta_out_r <= '0;
      zero_r <= 4'hf;
    end else begin
      alpha_r <= alpha_nxt;
      beta_r <= beta_nxt;
      gamma_r <= gamma_nxt;
      delta_r <= delta_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      alpha_out_r <= alpha_out_nxt;
      beta_out_r <= beta_out_nxt;
      gamma_out_r <= gamma_out_nxt;
      delta_out_r <= delta_out_nxt;
      zero_r <= zero_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign alpha_coef = alpha_out_r;
  assign beta_coef = beta_out_r;
  assign gamma_coef = gamma_out_r;
  assign delta_coef = delta_out_r;
  assign mant_zero = zero_r;

endmodule : lfcd_top

// barrel shift of a mantissa into a wider fixed-point word
module lfcd_shl #(
  parameter int MANT_W = 16,
  parameter int AMT_W = 8,
  parameter int OUT_W = 101
) (
  input wire logic [MANT_W-1:0] mant,
  input wire logic [AMT_W-1:0] amt,
  output logic [OUT_W-1:0] shifted
);

  logic [OUT_W-1:0] wide;

  assign wide = {{(OUT_W-MANT_W){1'b0}}, mant};
  assign shifted = wide << amt;

endmodule : lfcd_shl

//--- testbench/lfcd_sva.sv
// checker for the loop filter coefficient decoder
// assumes only the top module ports, one clock domain
`timescale 1ns/1ns
module lfcd_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [lfcd_pkg::ALPHA_OUT_W-1:0] alpha_coef,
  input wire logic signed [lfcd_pkg::BG_OUT_W-1:0] beta_coef,
  input wire logic signed [lfcd_pkg::BG_OUT_W-1:0] gamma_coef,
  input wire logic [lfcd_pkg::DELTA_OUT_W-1:0] delta_coef,
  input wire logic [3:0] mant_zero
);
  logic wr;
  logic [100:0] ea;
  logic [48:0] eb;
  logic [45:0] ed;
  assign wr = psel & penable & pready & pwrite;
  assign ea = 101'(pwdata[15:0]) <<
    (7'd63 - pwdata[21:16] + pwdata[24:22] + pwdata[28:25]);
  assign eb = 49'(pwdata[16:0]) << (5'd31 - pwdata[21:17]);
  assign ed = 46'(pwdata[14:0]) << (5'd31 - pwdata[19:15]);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_alpha;
    wr && paddr == 8'h00 |-> ##2 alpha_coef == $past(ea, 2);
  endproperty
  a_alpha: assert property (p_alpha) else $error("alpha wrong");
  property p_hold;
    !$past(wr && paddr == 8'h00, 2) |-> $stable(alpha_coef);
  endproperty
  a_hold: assert property (p_hold) else $error("alpha moved");
  property p_beta;
    wr && paddr == 8'h04 |-> ##2 beta_coef == -$past(eb, 2);
  endproperty
  a_beta: assert property (p_beta) else $error("beta wrong");
  property p_gamma;
    wr && paddr == 8'h08 |-> ##2 gamma_coef == -$past(eb, 2);
  endproperty
  a_gamma: assert property (p_gamma) else $error("gamma wrong");
  property p_delta;
    wr && paddr == 8'h0c |-> ##2 delta_coef == $past(ed, 2);
  endproperty
  a_delta: assert property (p_delta) else $error("delta wrong");
  property p_neg;
    beta_coef != 0 |-> beta_coef[48] && gamma_coef <= 0;
  endproperty
  a_neg: assert property (p_neg) else $error("not negated");
  property p_exact;
    wr && paddr == 8'h00 && pwdata[21:16] == 6'h3f |->
      ##2 alpha_coef[15:0] == $past(pwdata[15:0], 2);
  endproperty
  a_exact: assert property (p_exact) else $error("bits lost");
  cover property (wr && paddr == 8'h04);
  cover property (pslverr);
  cover property (mant_zero == 4'h1);
endmodule : lfcd_sva
bind lfcd_top lfcd_sva i_lfcd_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .alpha_coef(alpha_coef),
  .beta_coef(beta_coef), .gamma_coef(gamma_coef),
  .delta_coef(delta_coef), .mant_zero(mant_zero));

//--- testbench/testbench.sv
// self-checking bench for the loop filter coefficient decoder
// assumes apb slave answering without fixed wait, one clock
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  num_errors++; $display("ERROR %0t mismatch", $time); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic [100:0] alpha_coef;
  logic signed [48:0] beta_coef, gamma_coef;
  logic [45:0] delta_coef;
  logic [3:0] mant_zero;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  lfcd_top i_lfcd_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alpha_coef(alpha_coef), .beta_coef(beta_coef),
    .gamma_coef(gamma_coef), .delta_coef(delta_coef),
    .mant_zero(mant_zero));
  always #2 pclk = ~pclk;
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    logic [100:0] xa;
    logic [48:0] xb;
    logic [45:0] xd;
    xa = 101'(d[15:0]) << (7'd63 - d[21:16] + d[24:22] + d[28:25]);
    xb = -(49'(d[16:0]) << (5'd31 - d[21:17]));
    xd = 46'(d[14:0]) << (5'd31 - d[19:15]);
    apb(a, 1, d);
    `CHK(e, 1'b0)
    repeat (2) @(posedge pclk);
    #1;
    case (a)
      8'h00: `CHK(alpha_coef, xa)
      8'h04: `CHK(beta_coef, xb)
      8'h08: `CHK(gamma_coef, xb)
      default: `CHK(delta_coef, xd)
    endcase
    apb(a, 0, 32'h0);
    `CHK({e, r}, {1'b0, d})
  endtask : wc
  logic [39:0] tbl [9] = '{
    {8'h00, 32'h0006d0a8},
    {8'h00, 32'h1fc00001},
    {8'h00, 32'h003fffff},
    {8'h04, 32'h001b250b},
    {8'h04, 32'h0001ffff},
    {8'h08, 32'h001b3abb},
    {8'h08, 32'h003e0001},
    {8'h0c, 32'h0004420a},
    {8'h0c, 32'h000fffff}};
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    #1;
    `CHK({mant_zero, alpha_coef, beta_coef}, {4'hf, 150'h0})
    `CHK({gamma_coef, delta_coef, pready, pslverr, prdata}, 129'h0)
    foreach (tbl[i]) wc(tbl[i][39:32], tbl[i][31:0]);
    apb(8'h10, 1, 32'hffffffff);
    `CHK(e, 1'b0)
    apb(8'h10, 0, 32'h0);
    `CHK({e, r}, 33'h0)
    wc(8'h00, 32'h00010000);
    `CHK(mant_zero, 4'h1)
    apb(8'h10, 0, 32'h0);
    `CHK(r, 32'h0000_0001)
    apb(8'h14, 1, 32'hffffffff);
    `CHK(e, 1'b1)
    apb(8'h14, 0, 32'h0);
    `CHK({e, r}, {1'b1, 32'h0})
    apb(8'h00, 0, 32'h0);
    `CHK(r, 32'h0001_0000)
    end_sim();
  end
endmodule : testbench
